// >>> core/rma_params.svh
// constants of the registered macrocell array: sizes, reset values and timing counts
`ifndef RMA_PARAMS_SVH
`define RMA_PARAMS_SVH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define RMA_NUM_MC 8
`define RMA_NUM_IN 12
`define RMA_PT_PER_MC 8
`define RMA_NUM_SIG (`RMA_NUM_MC + `RMA_NUM_IN)
`define RMA_COLS (2 * `RMA_NUM_SIG)
`define RMA_ROWS (`RMA_NUM_MC * `RMA_PT_PER_MC)
`define RMA_ROW_AW 6
`define RMA_MC_AW 3

// ----------------------------------------
// user signature store
// ----------------------------------------
`define RMA_SIG_BYTES 8
`define RMA_SIG_WIDTH 8
`define RMA_SIG_AW 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define RMA_REG_RESET 1'b0
`define RMA_PIN_OUT_RESET 1'b1
`define RMA_ROW_ERASED {`RMA_COLS{1'b1}}

// ----------------------------------------
// timing
// ----------------------------------------
`define RMA_CLK_PERIOD_NS 20
`define RMA_POWER_ON_CLEAR_INTERVAL_NS 1000
`define RMA_CLEAR_CYC ((`RMA_POWER_ON_CLEAR_INTERVAL_NS + `RMA_CLK_PERIOD_NS - 1) / `RMA_CLK_PERIOD_NS)

`endif

// >>> core/rma_pkg.sv
// types of the registered macrocell array
`default_nettype none

package rma_pkg;

	// ----------------------------------------
	// macrocell and architecture modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MC_REG_OUT,
		MC_COMB_IO,
		MC_COMB_OUT,
		MC_INPUT
	} rma_mc_mode_t;

	typedef enum logic [1:0] {
		ARCH_REGISTERED,
		ARCH_COMPLEX,
		ARCH_SIMPLE
	} rma_arch_t;

	// ----------------------------------------
	// power-on clear sequence
	// ----------------------------------------
	typedef enum logic {
		CLR_BUSY,
		CLR_DONE
	} rma_clr_state_t;

endpackage : rma_pkg

`default_nettype wire

// >>> core/rma_sig_mem.sv
// small memory holding the user signature bytes, registered read
`default_nettype none
`include "rma_params.svh"

module rma_sig_mem
	import rma_pkg::*;
#(
	parameter int DEPTH = `RMA_SIG_BYTES,
	parameter int WIDTH = `RMA_SIG_WIDTH,
	parameter int AW = `RMA_SIG_AW
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic we,
	input wire logic re,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata,
	output logic rvalid
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_rdata;
	logic next_rvalid;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_comb begin
		next_rdata = rdata;
		next_rvalid = re;
		if (re) begin
			next_rdata = mem[addr];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= '0;
			rvalid <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

endmodule : rma_sig_mem

`default_nettype wire

// >>> core/rma_macrocell.sv
// one macrocell: product terms, sum, register, output enable and feedback
`default_nettype none
`include "rma_params.svh"

module rma_macrocell
	import rma_pkg::*;
#(
	parameter int COLS = `RMA_COLS,
	parameter int PTS = `RMA_PT_PER_MC,
	parameter bit OUTER = 1'b0,
	parameter bit CENTER = 1'b0
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [COLS-1:0] cols,
	input wire logic [PTS*COLS-1:0] rows,
	input wire rma_mc_mode_t mode,
	input wire rma_arch_t arch,
	input wire logic clk_rise,
	input wire logic oe_b,
	input wire logic pre_hit,
	input wire logic pre_val,
	input wire logic pin_in,
	output logic q,
	output logic pin_out,
	output logic pin_oe,
	output logic fb
);

	function automatic logic pt_eval(input logic [COLS-1:0] row, input logic [COLS-1:0] c);
		return &(~row | c);
	endfunction : pt_eval

	logic [PTS-1:0] pt;
	logic sum_all;
	logic sum_seven;
	logic is_reg;
	logic next_q;
	logic next_pin_out;
	logic next_pin_oe;

	// ----------------------------------------
	// and array and or sums
	// ----------------------------------------
	for (genvar i = 0; i < PTS; i++) begin : g_pt
		assign pt[i] = pt_eval(rows[i*COLS +: COLS], cols);
	end

	assign sum_all = |pt;
	assign sum_seven = |pt[PTS-1:1];
	assign is_reg = (arch == ARCH_REGISTERED) && (mode == MC_REG_OUT);

	// ----------------------------------------
	// register with preload
	// ----------------------------------------
	always_comb begin
		next_q = q;
		if (pre_hit) begin
			next_q = pre_val;
		end else if (clk_rise && is_reg) begin
			next_q = sum_all;
		end
	end

	// ----------------------------------------
	// pin driver
	// ----------------------------------------
	always_comb begin
		next_pin_out = 1'b1;
		next_pin_oe = 1'b0;
		case (arch)
			ARCH_REGISTERED: begin
				case (mode)
					MC_REG_OUT: begin
						next_pin_out = ~q;
						next_pin_oe = ~oe_b;
					end
					MC_COMB_IO, MC_COMB_OUT: begin
						next_pin_out = sum_seven;
						next_pin_oe = pt[0];
					end
					default: begin
						next_pin_out = 1'b1;
						next_pin_oe = 1'b0;
					end
				endcase
			end
			ARCH_COMPLEX: begin
				if (mode != MC_INPUT || OUTER) begin
					next_pin_out = sum_seven;
					next_pin_oe = pt[0];
				end
			end
			default: begin
				if (mode != MC_INPUT || CENTER) begin
					next_pin_out = sum_all;
					next_pin_oe = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			q <= `RMA_REG_RESET;
			pin_out <= `RMA_PIN_OUT_RESET;
			pin_oe <= 1'b0;
		end else begin
			q <= next_q;
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
		end
	end

	// ----------------------------------------
	// feedback into the and array
	// ----------------------------------------
	assign fb = is_reg ? q : ((arch == ARCH_COMPLEX && OUTER) ? pin_out : pin_in);

endmodule : rma_macrocell

`default_nettype wire

// >>> core/rma_top.sv
// registered macrocell array: configuration, preload, security, signature and eight macrocells
//
// Function
// - power-on clear drives every macrocell register low asynchronously.
// - registered output pins show the inverted register, so high after clear.
// - preload forces any single macrocell register to one or zero.
// - a set security fuse refuses verify readback and preload.
// - the 64-bit user signature stays readable regardless of security.
// - security fuse acts at once; programming sets it last.
// - each macrocell is registered output, combinatorial io, combinatorial output or input.
// - exactly three architecture modes chosen from the configuration.
// - registered mode whenever any macrocell uses its register.
// - registered macrocell uses the shared enable pin and the clock pin.
// - a registered macrocell sums eight product terms.
// - a combinatorial macrocell uses one enable term and seven sum terms, except in simple mode: eight sum terms, always enabled.
// - undriven inputs and io pins read high through pull-ups.
// - a macrocell configured as input drives its pin only if outer in complex mode or center in simple mode.
`default_nettype none
`include "rma_params.svh"

module rma_top
	import rma_pkg::*;
#(
	parameter int NUM_MC = `RMA_NUM_MC,
	parameter int NUM_IN = `RMA_NUM_IN,
	parameter int PTS = `RMA_PT_PER_MC,
	parameter int CLEAR_CYC = `RMA_CLEAR_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [NUM_IN-1:0] in_val,
	input wire logic [NUM_IN-1:0] in_drv,
	input wire logic clk_pin,
	input wire logic oe_pin_b,
	input wire logic [NUM_MC-1:0] io_in,
	input wire logic [NUM_MC-1:0] io_drv,
	output logic [NUM_MC-1:0] io_out,
	output logic [NUM_MC-1:0] io_oe,
	output logic [NUM_MC-1:0] reg_state,
	output logic clear_busy,
	output rma_arch_t arch_mode,
	input wire logic fuse_we,
	input wire logic [`RMA_ROW_AW-1:0] fuse_row,
	input wire logic [`RMA_COLS-1:0] fuse_data,
	input wire logic vfy_rd,
	input wire logic [`RMA_ROW_AW-1:0] vfy_row,
	output logic [`RMA_COLS-1:0] vfy_data,
	output logic vfy_valid,
	output logic vfy_refused,
	input wire logic cfg_we,
	input wire logic [`RMA_MC_AW-1:0] cfg_idx,
	input wire rma_mc_mode_t cfg_mode,
	input wire logic pre_we,
	input wire logic [`RMA_MC_AW-1:0] pre_idx,
	input wire logic pre_val,
	output logic pre_refused,
	input wire logic sec_set,
	output logic secured,
	input wire logic sig_we,
	input wire logic sig_rd,
	input wire logic [`RMA_SIG_AW-1:0] sig_addr,
	input wire logic [`RMA_SIG_WIDTH-1:0] sig_wdata,
	output logic [`RMA_SIG_WIDTH-1:0] sig_rdata,
	output logic sig_valid
);

	localparam int COLS = `RMA_COLS;
	localparam int ROWS = `RMA_ROWS;
	localparam int NSIG = NUM_MC + NUM_IN;
	localparam int CW = $clog2(CLEAR_CYC + 1);

	function automatic rma_arch_t arch_of(input rma_mc_mode_t m [NUM_MC]);
		logic any_reg;
		logic any_comb;
		any_reg = 1'b0;
		any_comb = 1'b0;
		for (int i = 0; i < NUM_MC; i++) begin
			any_reg = any_reg | (m[i] == MC_REG_OUT);
			any_comb = any_comb | (m[i] == MC_COMB_IO);
		end
		if (any_reg) begin
			return ARCH_REGISTERED;
		end else if (any_comb) begin
			return ARCH_COMPLEX;
		end
		return ARCH_SIMPLE;
	endfunction : arch_of

	logic [ROWS-1:0][COLS-1:0] fuse;
	logic [ROWS-1:0][COLS-1:0] next_fuse;
	rma_mc_mode_t mc_mode [NUM_MC];
	rma_mc_mode_t next_mc_mode [NUM_MC];
	rma_arch_t next_arch_mode;
	logic next_secured;
	logic sec_now;
	logic [COLS-1:0] next_vfy_data;
	logic next_vfy_valid;
	logic next_vfy_refused;
	logic next_pre_refused;
	logic pre_ok;
	rma_clr_state_t clr_state;
	rma_clr_state_t next_clr_state;
	logic [CW-1:0] clr_cnt;
	logic [CW-1:0] next_clr_cnt;
	logic clk_prev;
	logic clk_rise;
	logic [NUM_IN-1:0] in_eff;
	logic [NUM_MC-1:0] io_eff;
	logic [NUM_MC-1:0] fb;
	logic [NSIG-1:0] arr_in;
	logic [COLS-1:0] cols;

	// ----------------------------------------
	// power-on clear interval
	// ----------------------------------------
	always_comb begin
		next_clr_state = clr_state;
		next_clr_cnt = clr_cnt;
		case (clr_state)
			CLR_BUSY: begin
				if (clr_cnt == CW'(CLEAR_CYC - 1)) begin
					next_clr_state = CLR_DONE;
				end else begin
					next_clr_cnt = clr_cnt + CW'(1);
				end
			end
			default: begin
				next_clr_state = CLR_DONE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			clr_state <= CLR_BUSY;
			clr_cnt <= '0;
			clk_prev <= 1'b1;
		end else begin
			clr_state <= next_clr_state;
			clr_cnt <= next_clr_cnt;
			clk_prev <= clk_pin;
		end
	end

	assign clear_busy = (clr_state == CLR_BUSY);
	assign clk_rise = clk_pin & ~clk_prev & ~clear_busy;

	// ----------------------------------------
	// pins into the and array
	// ----------------------------------------
	assign in_eff = (in_val & in_drv) | ~in_drv;
	for (genvar i = 0; i < NUM_MC; i++) begin : g_io
		assign io_eff[i] = io_oe[i] ? io_out[i] : (io_drv[i] ? io_in[i] : 1'b1);
	end
	assign arr_in = {fb, in_eff};
	for (genvar k = 0; k < NSIG; k++) begin : g_cols
		assign cols[2*k] = arr_in[k];
		assign cols[2*k+1] = ~arr_in[k];
	end

	// ----------------------------------------
	// fuse array and macrocell configuration
	// ----------------------------------------
	always_comb begin
		next_fuse = fuse;
		next_mc_mode = mc_mode;
		if (fuse_we) begin
			next_fuse[fuse_row] = fuse_data;
		end
		if (cfg_we) begin
			next_mc_mode[cfg_idx] = cfg_mode;
		end
		next_arch_mode = arch_of(mc_mode);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int r = 0; r < ROWS; r++) begin
				fuse[r] <= `RMA_ROW_ERASED;
			end
			for (int i = 0; i < NUM_MC; i++) begin
				mc_mode[i] <= MC_INPUT;
			end
			arch_mode <= ARCH_SIMPLE;
		end else begin
			fuse <= next_fuse;
			mc_mode <= next_mc_mode;
			arch_mode <= next_arch_mode;
		end
	end

	// ----------------------------------------
	// security, verify and preload
	// ----------------------------------------
	assign sec_now = secured | sec_set;
	assign pre_ok = pre_we & ~sec_now;

	always_comb begin
		next_secured = sec_now;
		next_vfy_valid = vfy_rd & ~sec_now;
		next_vfy_refused = vfy_rd & sec_now;
		next_vfy_data = '0;
		if (next_vfy_valid) begin
			next_vfy_data = fuse[vfy_row];
		end
		next_pre_refused = pre_we & sec_now;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			secured <= 1'b0;
			vfy_valid <= 1'b0;
			vfy_refused <= 1'b0;
			vfy_data <= '0;
			pre_refused <= 1'b0;
		end else begin
			secured <= next_secured;
			vfy_valid <= next_vfy_valid;
			vfy_refused <= next_vfy_refused;
			vfy_data <= next_vfy_data;
			pre_refused <= next_pre_refused;
		end
	end

	// ----------------------------------------
	// macrocells
	// ----------------------------------------
	for (genvar i = 0; i < NUM_MC; i++) begin : g_mc
		rma_macrocell #(
			.COLS(COLS),
			.PTS(PTS),
			.OUTER((i == 0) || (i == NUM_MC - 1)),
			.CENTER((i == NUM_MC / 2 - 1) || (i == NUM_MC / 2))
		) u_mc (
			.mclk(mclk),
			.rst_b(rst_b),
			.cols(cols),
			.rows(fuse[i*PTS +: PTS]),
			.mode(mc_mode[i]),
			.arch(arch_mode),
			.clk_rise(clk_rise),
			.oe_b(oe_pin_b),
			.pre_hit(pre_ok && (pre_idx == `RMA_MC_AW'(i))),
			.pre_val(pre_val),
			.pin_in(io_eff[i]),
			.q(reg_state[i]),
			.pin_out(io_out[i]),
			.pin_oe(io_oe[i]),
			.fb(fb[i])
		);
	end

	// ----------------------------------------
	// user signature
	// ----------------------------------------
	rma_sig_mem #(
		.DEPTH(`RMA_SIG_BYTES),
		.WIDTH(`RMA_SIG_WIDTH),
		.AW(`RMA_SIG_AW)
	) u_sig (
		.mclk(mclk),
		.rst_b(rst_b),
		.we(sig_we),
		.re(sig_rd),
		.addr(sig_addr),
		.wdata(sig_wdata),
		.rdata(sig_rdata),
		.rvalid(sig_valid)
	);

endmodule : rma_top

`default_nettype wire

// >>> tb/rma_checker.sv
// port assertions of the macrocell array
`default_nettype none
`include "rma_params.svh"

module rma_checker
	import rma_pkg::*;
#(
	parameter int NUM_MC = `RMA_NUM_MC,
	parameter int CLEAR_CYC = `RMA_CLEAR_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [NUM_MC-1:0] reg_state,
	input wire logic [NUM_MC-1:0] io_out,
	input wire logic clear_busy,
	input wire logic pre_we,
	input wire logic [`RMA_MC_AW-1:0] pre_idx,
	input wire logic pre_val,
	input wire logic pre_refused,
	input wire logic sec_set,
	input wire logic secured,
	input wire logic vfy_rd,
	input wire logic vfy_valid,
	input wire logic vfy_refused,
	input wire logic sig_rd,
	input wire logic sig_valid
);
	// ----
	// clear length count
	// ----
	int busy_cnt;
	int next_busy_cnt;
	always_comb begin
		next_busy_cnt = busy_cnt + (clear_busy ? 1 : 0);
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= next_busy_cnt;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	chk_clear_low: assert property ($rose(rst_b) |-> reg_state == '0 && io_out == '1 && clear_busy)
		else $error("registers not clear at release");
	chk_clear_short: assert property ($fell(clear_busy) |-> busy_cnt == CLEAR_CYC)
		else $error("clear interval too short");
	chk_clear_long: assert property (clear_busy |-> busy_cnt < CLEAR_CYC)
		else $error("clear interval too long");
	chk_preload_sets: assert property (pre_we && !secured && !sec_set |=> reg_state[$past(pre_idx)] == $past(pre_val))
		else $error("preload value lost");
	chk_pre_refuse: assert property (pre_we && (secured || sec_set) |=> pre_refused)
		else $error("preload not refused");
	chk_vfy_refuse: assert property (vfy_rd && (secured || sec_set) |=> vfy_refused && !vfy_valid)
		else $error("verify not refused");
	chk_vfy_grant: assert property (vfy_rd && !secured && !sec_set |=> vfy_valid && !vfy_refused)
		else $error("verify not answered");
	chk_sec_sticky: assert property (sec_set || secured |=> secured)
		else $error("security fuse not held");
	chk_sig_open: assert property (sig_rd |=> sig_valid)
		else $error("signature read not answered");
	cover property ($fell(clear_busy));
	cover property (pre_refused);
	cover property (vfy_valid);
	cover property (sig_valid && secured);
endmodule : rma_checker

bind rma_top rma_checker #(.NUM_MC(NUM_MC), .CLEAR_CYC(CLEAR_CYC)) u_rma_checker (.mclk, .rst_b, .reg_state,
	.io_out, .clear_busy, .pre_we, .pre_idx, .pre_val, .pre_refused, .sec_set, .secured, .vfy_rd, .vfy_valid,
	.vfy_refused, .sig_rd, .sig_valid);

`default_nettype wire

// >>> tb/rma_board.sv
// board logic model driving input pins and the clock pin
`default_nettype none

module rma_board (
	input wire logic mclk,
	input wire logic clear_busy,
	output logic clk_pin,
	output logic [11:0] in_val,
	output logic [11:0] in_drv
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		clk_pin = 1'b0;
		in_val = 12'h000;
		in_drv = 12'h000;
	end
	// ----
	// one clock rise with settled inputs
	// ----
	task automatic rise(input logic [11:0] val, input logic [11:0] drv, output bit ok);
		int n;
		n = 0;
		while (clear_busy && n < 100) begin
			@(posedge mclk);
			#1;
			n++;
		end
		ok = !clear_busy;
		in_drv = drv;
		in_val = (val & drv) | (~in_val & ~drv);
		@(posedge mclk);
		#1;
		clk_pin = 1'b1;
		@(posedge mclk);
		#1;
		clk_pin = 1'b0;
	endtask : rise
endmodule : rma_board

`default_nettype wire

// >>> tb/registered_macrocell_array_bench.sv
// self-checking bench of the macrocell array
`default_nettype none
`include "rma_params.svh"

module registered_macrocell_array_bench
	import rma_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic oe_pin_b = 1'b1;
	logic fuse_we = 1'b0;
	logic vfy_rd = 1'b0;
	logic cfg_we = 1'b0;
	logic pre_we = 1'b0;
	logic pre_val = 1'b0;
	logic sec_set = 1'b0;
	logic sig_we = 1'b0;
	logic sig_rd = 1'b0;
	logic [5:0] fuse_row = 6'h00;
	logic [5:0] vfy_row = 6'h00;
	logic [39:0] fuse_data = 40'h0;
	logic [2:0] cfg_idx = 3'h0;
	logic [2:0] pre_idx = 3'h0;
	logic [2:0] sig_addr = 3'h0;
	logic [7:0] sig_wdata = 8'h00;
	rma_mc_mode_t cfg_mode = MC_INPUT;
	logic clk_pin, clear_busy, vfy_valid, vfy_refused, pre_refused, secured, sig_valid;
	logic [11:0] in_val, in_drv, v, d;
	logic [7:0] io_out, io_oe, reg_state, sig_rdata;
	logic [39:0] vfy_data;
	rma_arch_t arch_mode;
	logic [7:0] m_reg = 8'h00;
	logic [7:0] m_sig [8];
	logic [31:0] seed = 32'h9D0E1BDC;
	int mismatches = 0;
	int checks_done = 0;
	bit ok;

	rma_top #(.CLEAR_CYC(4)) u_rma_top (.mclk, .rst_b, .in_val, .in_drv, .clk_pin, .oe_pin_b, .io_in(8'h00),
		.io_drv(8'h00), .io_out, .io_oe, .reg_state, .clear_busy, .arch_mode, .fuse_we, .fuse_row, .fuse_data,
		.vfy_rd, .vfy_row, .vfy_data, .vfy_valid, .vfy_refused, .cfg_we, .cfg_idx, .cfg_mode, .pre_we, .pre_idx,
		.pre_val, .pre_refused, .sec_set, .secured, .sig_we, .sig_rd, .sig_addr, .sig_wdata, .sig_rdata, .sig_valid);
	rma_board u_rma_board (.mclk, .clear_busy, .clk_pin, .in_val, .in_drv);

	// ----
	// helpers
	// ----
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge mclk);
			#1;
		end
	endtask : cyc

	initial begin
		forever #10 mclk = ~mclk;
	end
	// ----
	// main sequence
	// ----
	initial begin
		cyc(12);
		rst_b = 1'b1;
		chk("reg_state", reg_state, 8'h00);
		chk("io_out", io_out, 8'hFF);
		chk("arch_mode", arch_mode, ARCH_SIMPLE);
		chk("io_oe", io_oe, 8'h00);
		sig_we = 1'b1;
		for (int i = 0; i < 8; i++) begin
			sig_addr = i[2:0];
			m_sig[i] = 8'(rnd());
			sig_wdata = m_sig[i];
			cyc(1);
		end
		sig_we = 1'b0;
		fuse_we = 1'b1;
		fuse_data = 40'h1;
		cyc(1);
		fuse_we = 1'b0;
		vfy_rd = 1'b1;
		for (int r = 0; r < 2; r++) begin
			vfy_row = r[5:0];
			cyc(1);
			chk("vfy_valid", vfy_valid, 1'h1);
			chk("vfy_data", vfy_data, r == 0 ? 40'h1 : {40{1'b1}});
		end
		vfy_rd = 1'b0;
		cfg_we = 1'b1;
		cfg_mode = MC_REG_OUT;
		cyc(1);
		cfg_we = 1'b0;
		oe_pin_b = 1'b0;
		cyc(2);
		chk("arch_mode", arch_mode, ARCH_REGISTERED);
		for (int k = 0; k < 6; k++) begin
			v = 12'(rnd());
			d = 12'(rnd());
			u_rma_board.rise(v, d, ok);
			if (!ok) begin
				mismatches++;
				end_sim();
			end
			m_reg[0] = d[0] ? v[0] : 1'b1;
			cyc(2);
			chk("reg_state", reg_state, m_reg);
			chk("io_out0", io_out[0], !m_reg[0]);
			chk("io_oe", io_oe, 8'h01);
		end
		oe_pin_b = 1'b1;
		cyc(2);
		chk("io_oe", io_oe, 8'h00);
		fuse_we = 1'b1;
		fuse_row = 6'h08;
		fuse_data = 40'h0;
		cyc(1);
		fuse_row = 6'h09;
		fuse_data = 40'h1;
		cyc(1);
		fuse_we = 1'b0;
		cfg_we = 1'b1;
		cfg_idx = 3'h1;
		cfg_mode = MC_COMB_OUT;
		cyc(1);
		cfg_we = 1'b0;
		v = 12'(rnd());
		d = 12'(rnd());
		u_rma_board.rise(v, d, ok);
		if (!ok) begin
			mismatches++;
		end
		m_reg[0] = d[0] ? v[0] : 1'b1;
		cyc(2);
		chk("io_oe", io_oe, 8'h02);
		chk("io_out1", io_out[1], m_reg[0]);
		chk("reg_state", reg_state, m_reg);
		pre_we = 1'b1;
		for (int k = 0; k < 4; k++) begin
			pre_idx = 3'(rnd());
			pre_val = 1'(rnd());
			m_reg[pre_idx] = pre_val;
			cyc(1);
			chk("reg_state", reg_state, m_reg);
		end
		pre_val = !m_reg[pre_idx];
		sec_set = 1'b1;
		vfy_rd = 1'b1;
		cyc(1);
		sec_set = 1'b0;
		pre_we = 1'b0;
		vfy_rd = 1'b0;
		chk("reg_state", reg_state, m_reg);
		chk("pre_refused", pre_refused, 1'h1);
		chk("vfy_refused", vfy_refused, 1'h1);
		chk("vfy_valid", vfy_valid, 1'h0);
		chk("secured", secured, 1'h1);
		sig_rd = 1'b1;
		for (int i = 0; i < 8; i++) begin
			sig_addr = i[2:0];
			cyc(1);
			chk("sig_valid", sig_valid, 1'h1);
			chk("sig_rdata", sig_rdata, m_sig[i]);
		end
		sig_rd = 1'b0;
		rst_b = 1'b0;
		#2;
		chk("reg_state", reg_state, 8'h00);
		chk("secured", secured, 1'h0);
		cyc(1);
		chk("io_out", io_out, 8'hFF);
		rst_b = 1'b1;
		cyc(2);
		end_sim();
	end
endmodule : registered_macrocell_array_bench

`default_nettype wire
